/* File: bench/cxr_cpu_model.sv */
`timescale 1ns/1ps
// CPU side stand-in: logs every extracted byte and every scheduler grant.
// Port 1 takes its grants late, so a held grant is exercised as well.
module cxr_cpu_model (
  // Clock.
  input wire logic clk_sys,
  // Scheduler side.
  input wire logic [1:0] grant_valid,
  input wire logic [1:0][2:0] grant_queue,
  output logic [1:0] grant_ack,
  // Frame side.
  input wire logic out_valid,
  input wire logic out_sop,
  input wire logic out_eop,
  input wire logic [7:0] out_data
);
  logic [9:0] rx_q[$];
  logic [2:0] gq[2][$];
  int eop_cnt = 0;
  int wait_cnt[2] = '{0, 0};
  logic [1:0] ack_ff = 2'h0;

  assign grant_ack = ack_ff;

  // A grant is taken at a falling edge, after a wait of three cycles per port index,
  // so the acknowledge is settled well before the design samples it.
  always @(negedge clk_sys) begin
    for (int p = 0; p < 2; p++) begin
      if (ack_ff[p]) begin
        ack_ff[p] <= 1'b0;
      end else if (grant_valid[p]) begin
        if (wait_cnt[p] >= p * 3) begin
          ack_ff[p] <= 1'b1;
          gq[p].push_back(grant_queue[p]);
          wait_cnt[p] <= 0;
        end else begin
          wait_cnt[p] <= wait_cnt[p] + 1;
        end
      end
    end
  end

  // Bytes are logged at the falling edge, where the registered outputs have settled.
  always @(negedge clk_sys) begin
    if (out_valid) begin
      rx_q.push_back({out_sop, out_eop, out_data});
      if (out_eop) begin
        eop_cnt++;
      end
    end
  end
endmodule

/* File: bench/cxr_top_tb.sv */
`timescale 1ns/1ps
module cxr_top_tb;
  import cxr_pkg::*;
  logic clk_sys, resetn, in_valid, in_sop, in_eop, in_ready, out_valid, out_sop, out_eop;
  logic [7:0] queue_map, queue_nonempty, in_data, out_data;
  logic [1:0] sched_round_robin, include_extract_header, grant_ack, grant_valid;
  logic [1:0][23:0] port_source_addr_low, port_source_addr_high;
  logic [1:0][2:0] grant_queue;
  logic [3:0] out_cpu_port;
  cxr_meta_type in_meta;
  int num_errors = 0;
  int compares = 0;

  cxr_top i_dut (.clk_sys, .resetn, .queue_map, .sched_round_robin, .include_extract_header,
    .port_source_addr_low, .port_source_addr_high, .queue_nonempty, .grant_ack, .grant_valid,
    .grant_queue, .in_valid, .in_sop, .in_eop, .in_data, .in_meta, .in_ready, .out_valid,
    .out_sop, .out_eop, .out_data, .out_cpu_port);
  cxr_cpu_model i_cpu (.clk_sys, .grant_valid, .grant_queue, .grant_ack, .out_valid, .out_sop,
    .out_eop, .out_data);

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Compare tasks print both values so a mismatch can be read off directly.
  task automatic chk_byte(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timeout;
    num_errors++;
    results();
  endtask

  // Frame bytes; byte 0 is odd so the swapped source address starts multicast.
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 29 + 51);
  endfunction

  // Expected extraction header, built field by field.
  function automatic logic [127:0] exp_hdr(input cxr_meta_type m);
    logic [127:0] h;
    logic hit;
    logic [15:0] t;
    h = '0;
    hit = m.copy_to_cpu_action | m.hit_once_action;
    t = 16'(m.frame_len) + LEN_BIAS;
    h[125:117] = (m.rewriter_operation[2:0] == OP_PTP_TWO_STEP) ?
      {m.ptp_id, OP_PTP_TWO_STEP} : m.rewriter_operation;
    h[116:85] = m.receive_time_value;
    h[84:79] = 6'(t % LEN_WORD);
    h[78:71] = 8'(t / LEN_WORD);
    h[46:43] = m.ingress_port_number;
    h[42:37] = hit ? m.rule_identifier : 6'h00;
    h[35:32] = (m.sampling_code inside {SAMPLE_RSV_LO, SAMPLE_RSV_HI}) ?
      SAMPLE_NONE : m.sampling_code;
    h[31] = hit;
    h[30] = m.drop_precedence;
    h[29:28] = m.learning_action;
    h[27:20] = m.cpu_queue_mask;
    h[19:17] = m.service_class;
    h[16] = m.tag_type;
    h[15:13] = m.pcp;
    h[12] = m.dei;
    h[11:0] = m.vid;
    return h;
  endfunction

  // Offers each byte from a falling edge and holds it until ready was seen high.
  task automatic send_frame(input cxr_meta_type m, input int n);
    int i;
    int k;
    i = 0;
    for (k = 0; k < 400 && i < n; k++) begin
      @(negedge clk_sys);
      in_valid = 1'b1;
      in_sop = (i == 0);
      in_eop = (i == n - 1);
      in_data = pat(i);
      in_meta = m;
      if (in_ready) begin
        i++;
      end
    end
    @(negedge clk_sys);
    in_valid = 1'b0;
    in_sop = 1'b0;
    in_eop = 1'b0;
    if (i < n) begin
      timeout();
    end
  endtask

  // Sends one frame and compares the whole extracted byte stream.
  task automatic run(input cxr_meta_type m, input int n);
    logic [127:0] h;
    logic [47:0] da, sa, nda, nsa;
    logic [9:0] e[$];
    logic hdr;
    int k;
    h = exp_hdr(m);
    hdr = include_extract_header[m.cpu_port_sel];
    for (k = 0; k < 6; k++) begin
      da[47-8*k -: 8] = pat(k);
      sa[47-8*k -: 8] = pat(k + 6);
    end
    nda = da;
    nsa = sa;
    if (m.rewriter_operation[3:0] == OP_SWAP) begin
      nda = sa;
      nsa = da;
      nsa[MCAST_BIT] = 1'b0;
    end else if (m.source_addr_replace_flag) begin
      nsa = {port_source_addr_high[m.cpu_port_sel], port_source_addr_low[m.cpu_port_sel]};
    end
    for (k = 0; hdr && k < 16; k++) e.push_back({k == 0, 1'b0, h[127-8*k -: 8]});
    for (k = 0; k < 12; k++) e.push_back({!hdr && k == 0, 1'b0,
      k < 6 ? nda[47-8*k -: 8] : nsa[95-8*k -: 8]});
    for (k = 12; k < n; k++) e.push_back({1'b0, k == n - 1, pat(k)});
    i_cpu.rx_q.delete();
    i_cpu.eop_cnt = 0;
    send_frame(m, n);
    for (k = 0; k < 300 && i_cpu.eop_cnt == 0; k++) @(negedge clk_sys);
    if (i_cpu.eop_cnt == 0) begin
      timeout();
    end
    chk_val(i_cpu.rx_q.size(), e.size());
    for (k = 0; k < e.size() && k < i_cpu.rx_q.size(); k++) chk_byte(i_cpu.rx_q[k], e[k]);
    chk_val(out_cpu_port, m.cpu_port_sel ? CPU_PORT_HI : CPU_PORT_LO);
  endtask

  // Swap with a header on port 11; every classification field is non-zero.
  task automatic t_swap_hdr;
    cxr_meta_type m;
    m = '0;
    m.rewriter_operation = 9'h008;
    m.receive_time_value = 32'hA5C3_1E77;
    m.frame_len = 14'h0014;
    m.ingress_port_number = 4'hB;
    m.rule_identifier = 6'h2D;
    m.copy_to_cpu_action = 1'b1;
    m.sampling_code = 4'hC;
    m.drop_precedence = 1'b1;
    m.learning_action = 2'h3;
    m.cpu_queue_mask = 8'h81;
    m.service_class = 3'h5;
    m.tag_type = 1'b1;
    m.pcp = 3'h6;
    m.dei = 1'b1;
    m.vid = 12'hABC;
    include_extract_header = 2'b01;
    run(m, 20);
  endtask

  // Two-step PTP with source replacement on port 12, shortest legal frame.
  task automatic t_ptp_replace;
    cxr_meta_type m;
    m = '0;
    m.rewriter_operation = 9'h003;
    m.ptp_id = 6'h2A;
    m.source_addr_replace_flag = 1'b1;
    m.hit_once_action = 1'b1;
    m.learning_action = 2'h1;
    m.cpu_queue_mask = 8'h40;
    m.frame_len = 14'h000D;
    m.cpu_port_sel = 1'b1;
    include_extract_header = 2'b11;
    run(m, 13);
  endtask

  // No header toward port 11: addresses follow straight after reset of the frame.
  task automatic t_plain;
    cxr_meta_type m;
    m = '0;
    m.source_addr_replace_flag = 1'b1;
    m.frame_len = 14'h001E;
    include_extract_header = 2'b10;
    run(m, 30);
  endtask

  // Sampling codes 12 to 15 without a rule hit; length lands on a word boundary.
  task automatic t_sampling;
    cxr_meta_type m;
    m = '0;
    m.rule_identifier = 6'h3F;
    m.learning_action = 2'h2;
    m.frame_len = 14'h0028;
    m.cpu_port_sel = 1'b1;
    include_extract_header = 2'b10;
    for (int c = 12; c < 16; c++) begin
      m.sampling_code = 4'(c);
      run(m, 40);
    end
  endtask

  // Round-robin then strict selection; port 1 holds its grant longer.
  task automatic t_sched;
    int k;
    i_cpu.gq[0].delete();
    sched_round_robin = 2'b01;
    queue_map = 8'h00;
    queue_nonempty = 8'h15;
    for (k = 0; k < 400 && i_cpu.gq[0].size() < 4; k++) @(negedge clk_sys);
    queue_nonempty = 8'h00;
    if (k == 400) begin
      timeout();
    end
    for (k = 0; k < 4; k++) chk_val(i_cpu.gq[0][k], (k * 2 + 2) % 6);
    repeat (20) @(negedge clk_sys);
    i_cpu.gq[0].delete();
    i_cpu.gq[1].delete();
    sched_round_robin = 2'b00;
    queue_map = 8'h20;
    queue_nonempty = 8'h25;
    for (k = 0; k < 400 && (i_cpu.gq[0].size() < 3 || i_cpu.gq[1].size() < 2); k++) begin
      @(negedge clk_sys);
    end
    queue_nonempty = 8'h00;
    if (k == 400) begin
      timeout();
    end
    for (k = 0; k < 3; k++) chk_val(i_cpu.gq[0][k], 2);
    for (k = 0; k < 2; k++) chk_val(i_cpu.gq[1][k], 5);
  endtask

  // Main sequence: reset, then the scenarios back to back.
  initial begin
    resetn = 1'b0;
    in_valid = 1'b0;
    in_sop = 1'b0;
    in_eop = 1'b0;
    in_data = 8'h00;
    in_meta = '0;
    queue_map = 8'h00;
    queue_nonempty = 8'h00;
    sched_round_robin = 2'b00;
    include_extract_header = 2'b00;
    port_source_addr_low = {24'h64_2086, 24'h13_5791};
    port_source_addr_high = {24'h0A_BCDE, 24'h02_ACE0};
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    t_sched();
    t_swap_hdr();
    t_ptp_replace();
    t_plain();
    t_sampling();
    results();
  end
endmodule

/* File: hdl/cxr_pkg.sv */
package cxr_pkg;
  // Sizes of the extraction path.
  localparam int NUM_Q = 8;
  localparam int NUM_CPU = 2;
  localparam int HDR_W = 128;
  localparam int HDR_LAST = 15;
  localparam int ADDR_LAST = 11;
  localparam int MAC_W = 48;
  localparam int ADDR_W = 96;
  localparam int BYTE_W = 8;
  localparam int LEN_W = 14;
  // Rewriter operation encodings.
  localparam logic [3:0] OP_SWAP = 4'h8;
  localparam logic [2:0] OP_PTP_TWO_STEP = 3'h3;
  localparam int MCAST_BIT = 40;
  // Frame length coding: bytes = LEN_WORD * word_count + last_length - LEN_BIAS.
  localparam logic [15:0] LEN_WORD = 16'h003C;
  localparam logic [15:0] LEN_BIAS = 16'h0050;
  // Sampling codes.
  localparam logic [3:0] SAMPLE_RSV_LO = 4'hD;
  localparam logic [3:0] SAMPLE_RSV_HI = 4'hE;
  localparam logic [3:0] SAMPLE_NONE = 4'hF;
  // CPU port numbers.
  localparam logic [3:0] CPU_PORT_LO = 4'hB;
  localparam logic [3:0] CPU_PORT_HI = 4'hC;
  // Header field positions.
  localparam int POS_REWRITER_OPERATION = 117;
  localparam int POS_RX_TIME = 85;
  localparam int POS_LAST_LEN = 79;
  localparam int POS_WORD_CNT = 71;
  localparam int POS_IN_PORT = 43;
  localparam int POS_RULE_ID = 37;
  localparam int POS_SAMPLE = 32;
  localparam int POS_HIT = 31;
  localparam int POS_DP = 30;
  localparam int POS_LEARN = 28;
  localparam int POS_CPU_QUEUE_MASK = 20;
  localparam int POS_CLASS = 17;
  localparam int POS_TAG = 16;
  localparam int POS_PCP = 13;
  localparam int POS_DEI = 12;
  localparam int POS_VID = 0;

  // Per-frame side-band information, valid with the first byte.
  typedef struct packed {
    logic [8:0] rewriter_operation;
    logic [5:0] ptp_id;
    logic source_addr_replace_flag;
    logic [31:0] receive_time_value;
    logic [LEN_W-1:0] frame_len;
    logic [3:0] ingress_port_number;
    logic [5:0] rule_identifier;
    logic copy_to_cpu_action;
    logic hit_once_action;
    logic [3:0] sampling_code;
    logic drop_precedence;
    logic [1:0] learning_action;
    logic [7:0] cpu_queue_mask;
    logic [2:0] service_class;
    logic tag_type;
    logic [2:0] pcp;
    logic dei;
    logic [11:0] vid;
    logic cpu_port_sel;
  } cxr_meta_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_COLLECT,
    ST_HEAD,
    ST_ADDR,
    ST_DATA
  } cxr_state_type;
endpackage

/* File: hdl/cxr_top.sv */
`timescale 1ns/1ps
// Functional notes
// - Operation code 8 swaps destination and source.
// - Clear bit 40 of swapped source address.
// - Replace flag loads per-port source address.
// - Eight queues, each mapped to port 11/12.
// - Per-port scheduler, strict or round-robin.
// - Prepend header when enabled for port.
// - Two-step PTP carries timestamp identifier.
// - Bits 116:85 hold receive timestamp.
// - Length coded as word count, last length.
// - Ingress port number at bit 43.
// - Rule identifier only when rule hit.
// - Sampling code, reserved codes never emitted.
// - Bit 31 set on copy or hit-once.
// - Bit 30 gives drop precedence.
// - Learning action at bits 29:28.
// - CPU queue mask at bits 27:20.
// - Class, PCP, DEI and VID reported.
// - Bit 16 gives tag type.
module cxr_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Configuration.
  input wire logic [cxr_pkg::NUM_Q-1:0] queue_map,
  input wire logic [cxr_pkg::NUM_CPU-1:0] sched_round_robin,
  input wire logic [cxr_pkg::NUM_CPU-1:0] include_extract_header,
  input wire logic [cxr_pkg::NUM_CPU-1:0][23:0] port_source_addr_low,
  input wire logic [cxr_pkg::NUM_CPU-1:0][23:0] port_source_addr_high,
  // Queue scheduling.
  input wire logic [cxr_pkg::NUM_Q-1:0] queue_nonempty,
  input wire logic [cxr_pkg::NUM_CPU-1:0] grant_ack,
  output logic [cxr_pkg::NUM_CPU-1:0] grant_valid,
  output logic [cxr_pkg::NUM_CPU-1:0][2:0] grant_queue,
  // Frame stream from the switch core.
  input wire logic in_valid,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [7:0] in_data,
  input wire cxr_pkg::cxr_meta_type in_meta,
  output logic in_ready,
  // Frame stream toward the CPU.
  output logic out_valid,
  output logic out_sop,
  output logic out_eop,
  output logic [7:0] out_data,
  output logic [3:0] out_cpu_port
);
  import cxr_pkg::*;

  cxr_state_type state_ff;
  logic [4:0] cnt_ff;
  logic in_ready_ff;
  logic sop_pend_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [HDR_W-1:0] hdr_ff;
  cxr_meta_type meta_ff;
  logic [NUM_CPU-1:0] gv_ff;
  logic [NUM_CPU-1:0][2:0] gq_ff;
  logic [NUM_CPU-1:0][2:0] last_ff;
  logic out_valid_ff;
  logic out_sop_ff;
  logic out_eop_ff;
  logic [7:0] out_data_ff;
  logic [3:0] out_port_ff;
  logic [NUM_Q-1:0] map_seen_ff;
  logic accept;
  logic [ADDR_W-1:0] cap;
  logic hdr_on;

  // Chooses a queue: highest index in strict mode, next after the last one in turn.
  function automatic logic [2:0] pick(input logic [NUM_Q-1:0] elig,
                                      input logic [2:0] last, input logic rr);
    logic [2:0] res;
    logic [2:0] idx;
    logic found;
    res = 3'h0;
    found = 1'b0;
    for (int i = 0; i < NUM_Q; i++) begin
      if (!rr && elig[i]) begin
        res = 3'(i);
      end
    end
    if (rr) begin
      for (int i = 1; i <= NUM_Q; i++) begin
        idx = 3'(int'(last) + i);
        if (elig[idx] && !found) begin
          res = idx;
          found = 1'b1;
        end
      end
    end
    return res;
  endfunction

  // Eligible queues of one CPU port; a set map bit steers a queue to port 12.
  function automatic logic [NUM_Q-1:0] elig_of(input int p);
    return queue_nonempty & (p == 1 ? queue_map : ~queue_map);
  endfunction

  // Builds the extraction header; unassigned positions stay zero.
  function automatic logic [HDR_W-1:0] build_hdr(input cxr_meta_type m);
    logic [HDR_W-1:0] h;
    logic [15:0] tot;
    logic [15:0] words;
    logic [15:0] rest;
    h = '0;
    tot = 16'(m.frame_len) + LEN_BIAS;
    words = tot / LEN_WORD;
    rest = tot - 16'(words * LEN_WORD);
    if (m.rewriter_operation[2:0] == OP_PTP_TWO_STEP) begin
      h[POS_REWRITER_OPERATION+:9] = {m.ptp_id, OP_PTP_TWO_STEP};
    end else begin
      h[POS_REWRITER_OPERATION+:9] = m.rewriter_operation;
    end
    h[POS_RX_TIME+:32] = m.receive_time_value;
    h[POS_LAST_LEN+:6] = rest[5:0];
    h[POS_WORD_CNT+:8] = words[7:0];
    h[POS_IN_PORT+:4] = m.ingress_port_number;
    if (m.copy_to_cpu_action || m.hit_once_action) begin
      h[POS_HIT] = 1'b1;
      h[POS_RULE_ID+:6] = m.rule_identifier;
    end
    if (m.sampling_code == SAMPLE_RSV_LO || m.sampling_code == SAMPLE_RSV_HI) begin
      h[POS_SAMPLE+:4] = SAMPLE_NONE;
    end else begin
      h[POS_SAMPLE+:4] = m.sampling_code;
    end
    h[POS_DP] = m.drop_precedence;
    h[POS_LEARN+:2] = m.learning_action;
    h[POS_CPU_QUEUE_MASK+:8] = m.cpu_queue_mask;
    h[POS_CLASS+:3] = m.service_class;
    h[POS_TAG] = m.tag_type;
    h[POS_PCP+:3] = m.pcp;
    h[POS_DEI] = m.dei;
    h[POS_VID+:12] = m.vid;
    return h;
  endfunction

  // Rewrites the captured address pair. Swap wins if both are asked for,
  // which only happens when the configuration is wrong.
  function automatic logic [ADDR_W-1:0] rewrite(input logic [ADDR_W-1:0] a,
                                                input cxr_meta_type m);
    logic [MAC_W-1:0] da;
    logic [MAC_W-1:0] sa;
    da = a[ADDR_W-1:MAC_W];
    sa = a[MAC_W-1:0];
    if (m.rewriter_operation[3:0] == OP_SWAP) begin
      da = a[MAC_W-1:0];
      sa = a[ADDR_W-1:MAC_W];
      sa[MCAST_BIT] = 1'b0;
    end else if (m.source_addr_replace_flag) begin
      sa = {port_source_addr_high[m.cpu_port_sel],
            port_source_addr_low[m.cpu_port_sel]};
    end
    return {da, sa};
  endfunction

  assign accept = in_valid && in_ready_ff;
  assign cap = {addr_ff[ADDR_W-BYTE_W-1:0], in_data};
  assign hdr_on = include_extract_header[meta_ff.cpu_port_sel];

  // Scheduler: a grant holds until the core acknowledges it, then a new pick.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      gv_ff <= '0;
      gq_ff <= '0;
      last_ff <= '0;
    end else begin
      for (int p = 0; p < NUM_CPU; p++) begin
        if (gv_ff[p] && grant_ack[p]) begin
          gv_ff[p] <= 1'b0;
        end else if (!gv_ff[p] && |elig_of(p)) begin
          gv_ff[p] <= 1'b1;
          gq_ff[p] <= pick(elig_of(p), last_ff[p], sched_round_robin[p]);
          last_ff[p] <= pick(elig_of(p), last_ff[p], sched_round_robin[p]);
        end
      end
    end
  end

  // Frame sequencing. Ready is registered, so it drops one cycle after the
  // twelfth address byte; the address bytes must be held before the header goes out.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      in_ready_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          in_ready_ff <= 1'b1;
          if (accept && in_sop) begin
            state_ff <= ST_COLLECT;
            cnt_ff <= 5'h01;
          end
        end
        ST_COLLECT: begin
          if (accept) begin
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == 5'(ADDR_LAST)) begin
              in_ready_ff <= 1'b0;
              cnt_ff <= '0;
              state_ff <= hdr_on ? ST_HEAD : ST_ADDR;
            end
          end
        end
        ST_HEAD: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == 5'(HDR_LAST)) begin
            cnt_ff <= '0;
            state_ff <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == 5'(ADDR_LAST)) begin
            cnt_ff <= '0;
            in_ready_ff <= 1'b1;
            state_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (accept && in_eop) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          in_ready_ff <= 1'b0;
        end
      endcase
    end
  end

  // Capture of side-band data, header and address bytes.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meta_ff <= '0;
      hdr_ff <= '0;
      addr_ff <= '0;
      map_seen_ff <= '0;
    end else begin
      map_seen_ff <= queue_map;
      if (state_ff == ST_IDLE && accept && in_sop) begin
        meta_ff <= in_meta;
        hdr_ff <= build_hdr(in_meta);
        addr_ff <= {{(ADDR_W-BYTE_W){1'b0}}, in_data};
      end else if (state_ff == ST_COLLECT && accept) begin
        if (cnt_ff == 5'(ADDR_LAST)) begin
          addr_ff <= rewrite(cap, meta_ff);
        end else begin
          addr_ff <= cap;
        end
      end else if (state_ff == ST_HEAD) begin
        hdr_ff <= {hdr_ff[HDR_W-BYTE_W-1:0], {BYTE_W{1'b0}}};
      end else if (state_ff == ST_ADDR) begin
        addr_ff <= {addr_ff[ADDR_W-BYTE_W-1:0], {BYTE_W{1'b0}}};
      end
    end
  end

  // Output stream: header, rewritten addresses, then the rest of the frame.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      out_valid_ff <= 1'b0;
      out_sop_ff <= 1'b0;
      out_eop_ff <= 1'b0;
      out_data_ff <= '0;
      out_port_ff <= CPU_PORT_LO;
      sop_pend_ff <= 1'b0;
    end else begin
      out_valid_ff <= 1'b0;
      out_sop_ff <= 1'b0;
      out_eop_ff <= 1'b0;
      if (state_ff == ST_IDLE && accept && in_sop) begin
        sop_pend_ff <= 1'b1;
        out_port_ff <= in_meta.cpu_port_sel ? CPU_PORT_HI : CPU_PORT_LO;
      end
      case (state_ff)
        ST_HEAD: begin
          out_valid_ff <= 1'b1;
          out_data_ff <= hdr_ff[HDR_W-1-:BYTE_W];
          out_sop_ff <= sop_pend_ff;
          sop_pend_ff <= 1'b0;
        end
        ST_ADDR: begin
          out_valid_ff <= 1'b1;
          out_data_ff <= addr_ff[ADDR_W-1-:BYTE_W];
          out_sop_ff <= sop_pend_ff;
          sop_pend_ff <= 1'b0;
        end
        ST_DATA: begin
          out_valid_ff <= accept;
          out_data_ff <= in_data;
          out_eop_ff <= accept && in_eop;
        end
        default: begin
          out_data_ff <= out_data_ff;
        end
      endcase
    end
  end

  assign in_ready = in_ready_ff;
  assign grant_valid = gv_ff;
  assign grant_queue = gq_ff;
  assign out_valid = out_valid_ff;
  assign out_sop = out_sop_ff;
  assign out_eop = out_eop_ff;
  assign out_data = out_data_ff;
  assign out_cpu_port = out_port_ff;

  // Checks on the design's own behaviour.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_head_run;
    (state_ff == ST_HEAD && cnt_ff == 5'h00) ##15 (state_ff == ST_HEAD);
  endsequence

  sequence s_addr_run;
    (state_ff == ST_ADDR && cnt_ff == 5'h00) ##11 (state_ff == ST_ADDR) ##1
      (state_ff == ST_DATA && in_ready_ff);
  endsequence

  AST_HEAD_SIXTEEN: assert property (
    (state_ff == ST_HEAD && cnt_ff == 5'h00) |-> s_head_run ##1 s_addr_run)
    else $error("Header phase did not last sixteen bytes.");

  AST_NO_INPUT_IN_INSERT: assert property (
    (state_ff == ST_HEAD || state_ff == ST_ADDR) |-> !in_ready ##1 out_valid)
    else $error("Input accepted or output idle during insertion.");

  AST_SWAP_ORDER: assert property (
    (state_ff == ST_COLLECT && accept && cnt_ff == 5'(ADDR_LAST) &&
     meta_ff.rewriter_operation[3:0] == OP_SWAP) |=>
    addr_ff[ADDR_W-1:MAC_W] == $past(cap[MAC_W-1:0]) &&
    addr_ff[MAC_W-1:MCAST_BIT+1] == $past(cap[ADDR_W-1:MCAST_BIT+MAC_W+1]))
    else $error("Address swap wrong.");

  AST_SWAP_UNICAST: assert property (
    (state_ff == ST_COLLECT && accept && cnt_ff == 5'(ADDR_LAST) &&
     meta_ff.rewriter_operation[3:0] == OP_SWAP) |=> !addr_ff[MCAST_BIT])
    else $error("Swapped source address left multicast.");

  AST_REPLACE: assert property (
    (state_ff == ST_COLLECT && accept && cnt_ff == 5'(ADDR_LAST) &&
     meta_ff.rewriter_operation[3:0] != OP_SWAP && meta_ff.source_addr_replace_flag) |=>
    addr_ff[MAC_W-1:0] == {port_source_addr_high[meta_ff.cpu_port_sel],
                           port_source_addr_low[meta_ff.cpu_port_sel]})
    else $error("Source address not replaced.");

  AST_SAMPLE_CODE: assert property (
    (state_ff == ST_HEAD && cnt_ff == 5'h00) |->
    hdr_ff[POS_SAMPLE+:4] != SAMPLE_RSV_LO && hdr_ff[POS_SAMPLE+:4] != SAMPLE_RSV_HI)
    else $error("Reserved sampling code produced.");

  AST_HIT_FLAG: assert property (
    (state_ff == ST_HEAD && cnt_ff == 5'h00) |->
    hdr_ff[POS_HIT] == (meta_ff.copy_to_cpu_action || meta_ff.hit_once_action) &&
    (hdr_ff[POS_HIT] || hdr_ff[POS_RULE_ID+:6] == 6'h00))
    else $error("Rule hit flag or identifier wrong.");

  AST_RESERVED_ZERO: assert property (
    (state_ff == ST_HEAD && cnt_ff == 5'h00) |->
    !hdr_ff[HDR_W-1] && hdr_ff[47+:24] == 24'h00_0000 && !hdr_ff[36])
    else $error("Reserved header bits not zero.");

  AST_STRICT_TOP: assert property (
    ($rose(gv_ff[0]) && !$past(sched_round_robin[0])) |->
    ($past(elig_of(0)) >> (int'(gq_ff[0]) + 1)) == 8'h00)
    else $error("Strict scheduler missed a higher queue.");

  AST_MAP_PORT: assert property (
    $rose(gv_ff[1]) |-> map_seen_ff[gq_ff[1]])
    else $error("Queue granted to wrong CPU port.");
endmodule
